// ===== design/sas_pkg.sv
// Package for the successive-approximation converter sequencer: map, fields, timing tables
package sas_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses on APB)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_MODE        = 8'h00;
	localparam logic [7:0] OFF_CHAN        = 8'h04;
	localparam logic [7:0] OFF_PORT_ANALOG = 8'h08;
	localparam logic [7:0] OFF_RESULT_WORD = 8'h0C;
	localparam logic [7:0] OFF_RESULT_HIGH = 8'h10;
	localparam logic [7:0] OFF_STATUS      = 8'h14;
	localparam logic [7:0] OFF_PORT_DATA   = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         MODE_RUN_BIT   = 0;
	localparam int         MODE_TSEL_LSB  = 1;
	localparam int         MODE_REFEN_BIT = 7;
	localparam int         RES_BITS       = 10;
	localparam int         NUM_CH         = 4;
	localparam logic [7:0] MODE_RST       = 8'h00;
	localparam logic [1:0] CHAN_RST       = 2'h0;
	localparam logic [3:0] PMC_RST        = 4'h0;
	localparam logic [9:0] SAR_MSB_TRIAL  = 10'h200;

	// ----------------------------------------------------------------
	// Timing in peripheral clock periods, indexed by timing_select_code
	// ----------------------------------------------------------------
	localparam logic [7:0] SMP_CYC [8] = '{8'd12, 8'd24, 8'd48, 8'd88,
	                                       8'd24, 8'd48, 8'd96, 8'd176};
	localparam logic [7:0] CONV_CYC [8] = '{8'd36, 8'd48, 8'd72, 8'd112,
	                                        8'd72, 8'd96, 8'd144, 8'd224};
	// Approximation window is split into this many equal slots, ten used
	localparam logic [7:0] STEP_DIV = 8'd12;

	// Mode register fields
	typedef struct packed {
		logic       ref_en;
		logic [2:0] spare;
		logic [2:0] tsel;
		logic       run;
	} sas_mode_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_APPROX = 2'b10,
		ST_SETTLE = 2'b11
	} sas_state_t;

endpackage : sas_pkg

// ===== design/sas_sar_adc_sequencer.sv
// Sequencer for a four-input 10-bit successive-approximation converter with APB registers
// Operation
// [RULE1] Four analog inputs, each converted to a 10-bit result.
// [RULE2] While running, convert the selected channel back to back, repeatedly.
// [RULE3] Pulse the completion interrupt once at the end of every conversion.
// [RULE4] Timing code sets sampling length: 12,24,48,88,24,48,96,176 clocks.
// [RULE5] Timing code sets total conversion length: 36,48,72,112,72,96,144,224 clocks.
// [RULE6] Software picks a sampling length long enough for its reference voltage.
// [RULE7] Software keeps total conversion length under 100 us and above minimum.
// [RULE8] Pins not chosen for conversion remain usable as digital inputs.
// [RULE9] Sample-and-hold captures at start and holds through approximation.
// [RULE10] Approximation decides one bit per step, MSB down to LSB, from comparator.
// [RULE11] After the LSB, copy the approximation value into the result register.
// [RULE12] Result word holds the value in low 10 bits, upper bits zero.
// [RULE13] High-byte result gets the upper 8 of 10 bits at every completion.
// [RULE14] Software stops conversion before changing the timing code.
// [RULE15] First result after starting with reference generator off is flagged invalid.
// [RULE16] Next sampling starts the cycle after update; clearing run aborts silently.
// [RULE17] Results and completion interrupt update in the same clock cycle.
`timescale 1ns/1ps
module sas_sar_adc_sequencer (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_cmp_out,
	input  wire logic [3:0]  i_pin_level,
	output logic             o_sh_hold,
	output logic      [9:0]  o_dac_code,
	output logic      [1:0]  o_chan_sel,
	output logic      [3:0]  o_digital_in_en,
	output logic             o_ref_gen_en,
	output logic             o_conversion_done_irq
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == sas_pkg::OFF_MODE) || (a == sas_pkg::OFF_CHAN) ||
		          (a == sas_pkg::OFF_PORT_ANALOG) || (a == sas_pkg::OFF_RESULT_WORD) ||
		          (a == sas_pkg::OFF_RESULT_HIGH) || (a == sas_pkg::OFF_STATUS) ||
		          (a == sas_pkg::OFF_PORT_DATA);
	endfunction : reg_hit

	function automatic logic [7:0] step_len(input logic [2:0] t);
		step_len = (sas_pkg::CONV_CYC[t] - sas_pkg::SMP_CYC[t]) / sas_pkg::STEP_DIV;
	endfunction : step_len

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sas_pkg::sas_mode_t  mode_ff;
	logic [1:0]          chan_ff;
	logic [3:0]          pmc_ff;
	sas_pkg::sas_state_t state_ff, nxt_state;
	logic [7:0]          cnt_ff, nxt_cnt;
	logic [7:0]          sc_ff, nxt_sc;
	logic [3:0]          bit_ff, nxt_bit;
	logic [9:0]          sar_ff, nxt_sar;
	logic [9:0]          res_ff;
	logic [7:0]          resh_ff;
	logic [2:0]          tsel_lat_ff;
	logic                bad_pend_ff;
	logic                res_invalid_ff;
	logic                irq_ff;
	logic                hold_ff;
	logic [1:0]          csel_ff;
	logic [3:0]          din_en_ff;
	wire  [3:0]          nxt_din_en;
	logic                cmp_q_ff;
	logic [3:0]          pin_s1_ff, pin_s2_ff;
	logic [31:0]         prdata_ff;
	logic                pready_ff, pslverr_ff;

	// ----------------------------------------------------------------
	// APB decode; no wait state, read data is registered from a flop during the setup phase
	// ----------------------------------------------------------------
	wire        setup_ph = i_psel & ~i_penable;
	wire        wr_take  = i_psel & i_penable & pready_ff & i_pwrite;
	wire        hit      = reg_hit(i_paddr);
	wire [31:0] rd_mux   =
		(i_paddr == sas_pkg::OFF_MODE)        ? {24'h00_0000, mode_ff} :
		(i_paddr == sas_pkg::OFF_CHAN)        ? {30'h0000_0000, chan_ff} :
		(i_paddr == sas_pkg::OFF_PORT_ANALOG) ? {28'h000_0000, pmc_ff} :
		(i_paddr == sas_pkg::OFF_RESULT_WORD) ? {22'h00_0000, res_ff} : // [RULE12]
		(i_paddr == sas_pkg::OFF_RESULT_HIGH) ? {24'h00_0000, resh_ff} :
		(i_paddr == sas_pkg::OFF_STATUS)      ? {30'h0000_0000, hold_ff, res_invalid_ff} :
		(i_paddr == sas_pkg::OFF_PORT_DATA)   ? {28'h000_0000, pin_s2_ff & din_en_ff} :
		                                        32'h0000_0000;

	// Bus answer flops
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= setup_ph ? rd_mux : prdata_ff;
			pready_ff  <= setup_ph;
			pslverr_ff <= setup_ph & ~hit;
		end
	end

	// Control registers; result and status registers are read only
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mode_ff <= sas_pkg::MODE_RST;
			chan_ff <= sas_pkg::CHAN_RST;
			pmc_ff  <= sas_pkg::PMC_RST;
		end else if (wr_take) begin
			if (i_paddr == sas_pkg::OFF_MODE)        mode_ff <= i_pwdata[7:0];
			if (i_paddr == sas_pkg::OFF_CHAN)        chan_ff <= i_pwdata[1:0];
			if (i_paddr == sas_pkg::OFF_PORT_ANALOG) pmc_ff  <= i_pwdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmp_q_ff  <= 1'b0;
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
		end else begin
			cmp_q_ff  <= i_cmp_out; // Comparator settles in one clock; two stages miss a short step
			pin_s1_ff <= i_pin_level;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	wire       run      = mode_ff.run;
	wire [7:0] smp_last = sas_pkg::SMP_CYC[tsel_lat_ff] - 8'd1;
	wire [7:0] cnv_last = sas_pkg::CONV_CYC[tsel_lat_ff] - 8'd1;
	wire [7:0] stp_last = step_len(tsel_lat_ff) - 8'd1;
	wire       done_now = (state_ff == sas_pkg::ST_SETTLE) && (cnt_ff == cnv_last) && run;
	wire       start    = (state_ff == sas_pkg::ST_IDLE) && run;
	// New timing code and channel are only taken at a conversion start
	wire       relatch  = start | done_now; // [RULE2] [RULE14]

	// Next-state logic; comparator high keeps the trial bit
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff + 8'd1;
		nxt_sc    = sc_ff;
		nxt_bit   = bit_ff;
		nxt_sar   = sar_ff;
		case (state_ff)
			sas_pkg::ST_IDLE: begin
				nxt_cnt = 8'd0;
				if (run) nxt_state = sas_pkg::ST_SAMPLE;
			end
			sas_pkg::ST_SAMPLE: begin
				if (cnt_ff == smp_last) begin // [RULE4]
					nxt_state = sas_pkg::ST_APPROX;
					nxt_sar   = sas_pkg::SAR_MSB_TRIAL;
					nxt_bit   = 4'd9;
					nxt_sc    = 8'd0;
				end
			end
			sas_pkg::ST_APPROX: begin
				nxt_sc = sc_ff + 8'd1;
				if (sc_ff == stp_last) begin // [RULE10]
					nxt_sc          = 8'd0;
					nxt_sar[bit_ff] = cmp_q_ff;
					if (bit_ff != 4'd0) begin
						nxt_sar[bit_ff - 4'd1] = 1'b1;
						nxt_bit                = bit_ff - 4'd1;
					end else begin
						nxt_state = sas_pkg::ST_SETTLE;
					end
				end
			end
			sas_pkg::ST_SETTLE: begin
				if (cnt_ff == cnv_last) begin // [RULE5]
					nxt_state = sas_pkg::ST_SAMPLE; // [RULE16]
					nxt_cnt   = 8'd0;
				end
			end
			default: nxt_state = sas_pkg::ST_IDLE;
		endcase
		// Clearing run drops the conversion; results stay as they were
		if (!run) nxt_state = sas_pkg::ST_IDLE; // [RULE16]
	end

	// Sequencer registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_ff    <= sas_pkg::ST_IDLE;
			cnt_ff      <= 8'd0;
			sc_ff       <= 8'd0;
			bit_ff      <= 4'd0;
			sar_ff      <= 10'h000;
			tsel_lat_ff <= 3'h0;
			csel_ff     <= 2'h0;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			sc_ff       <= nxt_sc;
			bit_ff      <= nxt_bit;
			sar_ff      <= nxt_sar;
			tsel_lat_ff <= relatch ? mode_ff.tsel : tsel_lat_ff;
			csel_ff     <= relatch ? chan_ff : csel_ff; // [RULE9]
		end
	end

	// Results and interrupt move together on the completion edge
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			res_ff         <= 10'h000;
			resh_ff        <= 8'h00;
			irq_ff         <= 1'b0;
			bad_pend_ff    <= 1'b0;
			res_invalid_ff <= 1'b0;
		end else begin
			res_ff         <= done_now ? sar_ff : res_ff; // [RULE1] [RULE11] [RULE17]
			resh_ff        <= done_now ? sar_ff[9:2] : resh_ff; // [RULE13]
			irq_ff         <= done_now; // [RULE3]
			// Reference not settled: first result of this run is unusable
			bad_pend_ff    <= start ? ~mode_ff.ref_en : (bad_pend_ff & ~done_now); // [RULE15]
			res_invalid_ff <= done_now ? bad_pend_ff : res_invalid_ff; // [RULE15]
		end
	end

	// Per-pin digital input enable; only the selected analog-mode pin drops out
	for (genvar gi = 0; gi < sas_pkg::NUM_CH; gi++) begin : g_pin
		assign nxt_din_en[gi] = ~(run && pmc_ff[gi] && (chan_ff == 2'(gi))); // [RULE8]
	end

	// Hold while approximating; one process owns all pin-enable bits
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hold_ff   <= 1'b0;
			din_en_ff <= 4'hF;
		end else begin
			hold_ff   <= (nxt_state == sas_pkg::ST_APPROX) || (nxt_state == sas_pkg::ST_SETTLE);
			din_en_ff <= nxt_din_en; // [RULE8]
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_prdata              = prdata_ff;
	assign o_pready              = pready_ff;
	assign o_pslverr             = pslverr_ff;
	assign o_sh_hold             = hold_ff;
	assign o_dac_code            = sar_ff;
	assign o_chan_sel            = csel_ff;
	assign o_digital_in_en       = din_en_ff;
	assign o_ref_gen_en          = mode_ff.ref_en;
	assign o_conversion_done_irq = irq_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_irq_single_pulse: assert property (irq_ff |=> !irq_ff [*3]) // [RULE3]
		else $error("completion interrupt longer than one cycle");
	a_result_with_irq: assert property ($changed(res_ff) |-> irq_ff) // [RULE17]
		else $error("result changed without completion interrupt");
	a_result_from_sar: assert property (irq_ff |-> res_ff == $past(sar_ff)) // [RULE11]
		else $error("result differs from approximation value");
	a_high_byte_copy: assert property (irq_ff |-> resh_ff == res_ff[9:2]) // [RULE13]
		else $error("high byte not upper eight result bits");
	a_word_upper_zero: assert property ((setup_ph && i_paddr == sas_pkg::OFF_RESULT_WORD)
		|=> o_prdata[31:10] == 22'h00_0000) // [RULE12]
		else $error("result word upper bits not zero");
	a_conv_length: assert property (irq_ff |-> $past(cnt_ff) == $past(cnv_last)) // [RULE5]
		else $error("conversion length wrong");
	a_sample_length: assert property ($rose(hold_ff) |-> $past(cnt_ff) == smp_last) // [RULE4]
		else $error("sampling length wrong");
	a_msb_first: assert property ($rose(hold_ff) |-> sar_ff == sas_pkg::SAR_MSB_TRIAL) // [RULE10]
		else $error("approximation did not start at MSB");
	a_hold_channel: assert property (hold_ff && $past(hold_ff) |-> $stable(csel_ff)) // [RULE9]
		else $error("channel moved during hold");
	a_abort_silent: assert property (!run |=> state_ff == sas_pkg::ST_IDLE && !irq_ff) // [RULE16]
		else $error("conversion not aborted");
	a_restart_next: assert property (irq_ff |-> state_ff == sas_pkg::ST_SAMPLE
		&& cnt_ff == 8'd0 && !hold_ff) // [RULE2]
		else $error("next sampling did not start");
	a_one_analog_pin: assert property ($countones(~din_en_ff) <= 1) // [RULE8]
		else $error("more than one pin taken from digital use");

	c_conversion_done: cover property (irq_ff);
	c_abort_in_hold: cover property (hold_ff ##1 !run);
	c_invalid_first: cover property (irq_ff && res_invalid_ff);

endmodule : sas_sar_adc_sequencer

// ===== verification/sas_afe_model.sv
// Behavioural analog front end: sample-and-hold, resistor string and comparator
`timescale 1ns/1ps
module sas_afe_model (
	input  wire logic            i_mclk,
	input  wire logic            i_sh_hold,
	input  wire logic [9:0]      i_dac_code,
	input  wire logic [1:0]      i_chan_sel,
	input  wire logic [3:0][9:0] i_level,
	output logic                 o_cmp_out
);
	logic [9:0] held_ff = 10'h000;
	logic       junk_ff = 1'b0;

	// Capture at the hold edge; later input moves never reach the comparator
	always @(posedge i_sh_hold) begin
		held_ff <= i_level[i_chan_sel];
	end

	// Outside hold the comparator output is meaningless, so it toggles
	always @(posedge i_mclk) begin
		junk_ff <= ~junk_ff;
	end

	// Comparator: 1 when the held level is at or above the trial code
	assign o_cmp_out = i_sh_hold ? (held_ff >= i_dac_code) : junk_ff;
endmodule : sas_afe_model

// ===== verification/test_sar_adc_sequencer.sv
// Self-checking testbench for the converter sequencer with APB master and front-end model
`timescale 1ns/1ps
module test_sar_adc_sequencer;
	typedef struct packed {logic rd; logic err; logic [31:0] d;} sas_note_t;
	logic            i_mclk = 1'b0;
	logic            i_rst = 1'b1;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0000_0000;
	logic [3:0]      pin_level = 4'h0;
	logic [3:0][9:0] level = '0;
	logic [31:0]     o_prdata;
	logic            o_pready, o_pslverr, cmp_out, o_sh_hold, o_ref_gen_en, irq;
	logic [9:0]      o_dac_code;
	logic [1:0]      o_chan_sel;
	logic [3:0]      o_digital_in_en;
	logic [15:0]     rnd = 16'h0024;
	sas_note_t       notes[$];
	sas_note_t       nt;
	int              n_fail = 0, cmp_count = 0, n_irq = 0, s, t, n0;
	logic [9:0]      last;

	always #12.5 i_mclk = ~i_mclk;

	sas_sar_adc_sequencer dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_cmp_out(cmp_out), .i_pin_level(pin_level), .o_sh_hold(o_sh_hold),
		.o_dac_code(o_dac_code), .o_chan_sel(o_chan_sel), .o_digital_in_en(o_digital_in_en),
		.o_ref_gen_en(o_ref_gen_en), .o_conversion_done_irq(irq));

	sas_afe_model afe (.i_mclk(i_mclk), .i_sh_hold(o_sh_hold), .i_dac_code(o_dac_code),
		.i_chan_sel(o_chan_sel), .i_level(level), .o_cmp_out(cmp_out));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			n_fail++;
		end
	endtask : check

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// APB master: request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
	                   input logic [31:0] exp, input logic err);
		int k;
		k = 0;
		notes.push_back('{rd: !w, err: err, d: exp});
		@(posedge i_mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			k++;
		end while (!o_pready && k < 50);
		if (!o_pready) n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Monitor takes the oldest note at every completed transfer
	always @(posedge i_mclk) begin
		if (psel && penable && o_pready) begin
			nt = notes.pop_front();
			check("pslverr", 32'(o_pslverr), 32'(nt.err));
			if (nt.rd) check("prdata", o_prdata, nt.d);
		end
		if (irq) n_irq++;
	end

	task automatic wait_irq;
		int k;
		k = 0;
		do begin
			@(negedge i_mclk);
			k++;
		end while (!irq && k < 1000);
		check("irq_arrives", 32'(irq), 32'h0000_0001);
	endtask : wait_irq

	// Hold-low and total length of one conversion, from one completion to the next
	task automatic measure(output int sl, output int tl);
		wait_irq();
		sl = 0;
		tl = 0;
		do begin
			if (!o_sh_hold) sl++;
			tl++;
			@(negedge i_mclk);
			if (tl == 1) check("irq_pulse", 32'(irq), 32'h0000_0000);
		end while (!irq && tl < 400);
	endtask : measure

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'b0;
		apb(0, sas_pkg::OFF_MODE, 0, 32'(sas_pkg::MODE_RST), 0);
		apb(0, sas_pkg::OFF_CHAN, 0, 32'(sas_pkg::CHAN_RST), 0);
		apb(0, sas_pkg::OFF_PORT_ANALOG, 0, 32'(sas_pkg::PMC_RST), 0);
		apb(1, 8'h1C, 32'h0000_0001, 0, 1);
		apb(0, 8'h1C, 0, 0, 1);
		apb(1, sas_pkg::OFF_RESULT_WORD, 32'hFFFF_FFFF, 0, 0);
		apb(0, sas_pkg::OFF_RESULT_WORD, 0, 32'h0000_0000, 0);
		// Every timing code, channel rotating, random held levels; the ideal front end
		// settles at once, so codes too short for a real reference still convert here
		for (int c = 0; c < 8; c++) begin
			for (int j = 0; j < 4; j++) begin
				rnd = lfsr(lfsr(rnd));
				level[j] <= rnd[9:0];
			end
			pin_level <= rnd[13:10];
			apb(1, sas_pkg::OFF_CHAN, 32'(c % 4), 0, 0);
			apb(1, sas_pkg::OFF_PORT_ANALOG, 32'h0000_000F, 0, 0);
			apb(1, sas_pkg::OFF_MODE, 32'({1'b1, 3'h0, 3'(c), 1'b1}), 0, 0);
			measure(s, t);
			check("sample_len", 32'(s), 32'(sas_pkg::SMP_CYC[c]));
			check("conv_len", 32'(t), 32'(sas_pkg::CONV_CYC[c]));
			check("chan_sel", 32'(o_chan_sel), 32'(c % 4));
			check("dig_en", 32'(o_digital_in_en), 32'(4'hF & ~(4'h1 << (c % 4))));
			apb(0, sas_pkg::OFF_PORT_DATA, 0, 32'(pin_level & ~(4'h1 << (c % 4))), 0);
			apb(1, sas_pkg::OFF_MODE, 32'h0000_0080, 0, 0);
			last = level[c % 4];
			apb(0, sas_pkg::OFF_RESULT_WORD, 0, 32'(last), 0);
			apb(0, sas_pkg::OFF_RESULT_HIGH, 0, 32'(last[9:2]), 0);
		end
		// Abort in mid-conversion: no completion, results untouched
		level <= ~level;
		n0 = n_irq;
		// Code 7 meets the shortest sampling and conversion limits at this clock
		apb(1, sas_pkg::OFF_MODE, 32'h0000_008F, 0, 0);
		repeat (200) @(posedge i_mclk);
		@(negedge i_mclk);
		check("abort_in_hold", 32'(o_sh_hold), 32'h0000_0001);
		apb(1, sas_pkg::OFF_MODE, 32'h0000_0080, 0, 0);
		repeat (300) @(posedge i_mclk);
		check("abort_irq", 32'(n_irq), 32'(n0));
		apb(0, sas_pkg::OFF_RESULT_WORD, 0, 32'(last), 0);
		// Start without the reference generator: first result flagged only
		apb(1, sas_pkg::OFF_MODE, 32'h0000_0001, 0, 0);
		@(negedge i_mclk);
		check("ref_en", 32'(o_ref_gen_en), 32'h0000_0000);
		wait_irq();
		apb(0, sas_pkg::OFF_STATUS, 0, 32'h0000_0001, 0);
		wait_irq();
		apb(0, sas_pkg::OFF_STATUS, 0, 32'h0000_0000, 0);
		apb(1, sas_pkg::OFF_MODE, 32'h0000_0000, 0, 0);
		repeat (4) @(posedge i_mclk);
		give_verdict();
	end

	// Watchdog: the whole run needs well under this span
	initial begin
		#(25 * 40000);
		n_fail++;
		give_verdict();
	end
endmodule : test_sar_adc_sequencer
